/* logic/sst_tx.sv */
// Purpose: Synchronous slave transmit path with holding and shift register.
// Assumes: External master drives the shift clock; data changes on its
//          falling edge, the master samples on the rising edge.
// Notes: Registers are reached over Avalon-MM with waitrequest.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Clearing master clock select (bit 7) selects synchronous slave mode.
// - Shift clock comes only from the external pin; never generated here.
// - Transfers continue in sleep because the clock is external.
// - Slave transmit uses same holding, shift and flag sequencing as master.
// - Two words queued then sleep: first word moves to shift at once.
// - Second word stays in holding; transmit flag stays clear meanwhile.
// - After first word shifts out, second moves in and flag sets on the same clock.
// - Flag with interrupt enable wakes chip; global enable gives interrupt (here peripheral enable, bit 6, is needed too).
module sst_tx (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Serial pins
    input wire logic serial_clock_pin,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    // Power and interrupts
    input wire logic sleep_mode,
    output logic wake_request,
    output logic irq
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    sst_pkg::sst_ctrl_t ctrl_r;
    logic [7:0] rx_status_r;
    logic [7:0] baud_ctrl_r;
    logic [7:0] div_high_r;
    logic [7:0] div_low_r;
    logic [7:0] irq_mask_r;
    logic flag_r;
    logic sent_r;
    logic hold_full_r;
    sst_pkg::sst_word_t hold_r;
    sst_pkg::sst_word_t shift_r;
    sst_pkg::sst_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic sclk_prev_r;
    logic sclk;
    logic access_done_r;

    function automatic logic is_reg(input logic [4:0] addr,
                                    input logic [4:0] ref_addr);
        is_reg = (addr == ref_addr);
    endfunction : is_reg

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    logic req;
    logic wr_take;
    logic rd_take;
    logic lane0;
    logic slave_mode;
    logic port_live;
    logic sclk_rise;
    logic sclk_fall;
    logic load_shift;
    logic shift_done;
    logic pending;

    assign req = (avs_read | avs_write) & ~access_done_r;
    assign wr_take = avs_write & ~avs_waitrequest;
    assign rd_take = avs_read & ~access_done_r;
    assign lane0 = avs_byteenable[0];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            access_done_r <= 1'b0;
        end else begin
            access_done_r <= req;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~req;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_response <= 2'h0;
        end else if (req) begin
            avs_response <= (avs_address > sst_pkg::ADDR_IRQ_MASK ||
                             avs_address[1:0] != 2'h0) ? 2'h2 : 2'h0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (rd_take) begin
            unique case (avs_address)
                sst_pkg::ADDR_TX_STATUS: begin
                    avs_readdata <= {24'h0, ctrl_r.master_clock_select,
                        ctrl_r.nine_bit_transmit_enable,
                        ctrl_r.transmit_enable_bit, ctrl_r.sync_select,
                        2'b00, state_r == sst_pkg::ST_IDLE,
                        ctrl_r.ninth_transmit_bit};
                end
                sst_pkg::ADDR_RX_STATUS: avs_readdata <= {24'h0, rx_status_r};
                sst_pkg::ADDR_BAUD_CTRL: avs_readdata <= {24'h0, baud_ctrl_r};
                sst_pkg::ADDR_DIV_HIGH: avs_readdata <= {24'h0, div_high_r};
                sst_pkg::ADDR_DIV_LOW: avs_readdata <= {24'h0, div_low_r};
                sst_pkg::ADDR_IRQ_STATUS: begin
                    avs_readdata <= {30'h0, sent_r, flag_r};
                end
                sst_pkg::ADDR_IRQ_MASK: avs_readdata <= {24'h0, irq_mask_r};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= '{master_clock_select: 1'b0,
                        nine_bit_transmit_enable: 1'b0,
                        transmit_enable_bit: 1'b0,
                        sync_select: 1'b0,
                        ninth_transmit_bit: 1'b0};
        end else if (wr_take && lane0 &&
                     is_reg(avs_address, sst_pkg::ADDR_TX_STATUS)) begin
            ctrl_r.master_clock_select <=
                avs_writedata[sst_pkg::TXS_MASTER_CLK];
            ctrl_r.nine_bit_transmit_enable <=
                avs_writedata[sst_pkg::TXS_NINE_BIT];
            ctrl_r.transmit_enable_bit <= avs_writedata[sst_pkg::TXS_TX_EN];
            ctrl_r.sync_select <= avs_writedata[sst_pkg::TXS_SYNC];
            ctrl_r.ninth_transmit_bit <= avs_writedata[sst_pkg::TXS_NINTH];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_status_r <= sst_pkg::RXS_RESET;
        end else if (wr_take && lane0 &&
                     is_reg(avs_address, sst_pkg::ADDR_RX_STATUS)) begin
            rx_status_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            baud_ctrl_r <= sst_pkg::BYTE_RESET;
        end else if (wr_take && lane0 &&
                     is_reg(avs_address, sst_pkg::ADDR_BAUD_CTRL)) begin
            baud_ctrl_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_high_r <= sst_pkg::BYTE_RESET;
        end else if (wr_take && lane0 &&
                     is_reg(avs_address, sst_pkg::ADDR_DIV_HIGH)) begin
            div_high_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_low_r <= sst_pkg::BYTE_RESET;
        end else if (wr_take && lane0 &&
                     is_reg(avs_address, sst_pkg::ADDR_DIV_LOW)) begin
            div_low_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_mask_r <= sst_pkg::BYTE_RESET;
        end else if (wr_take && lane0 &&
                     is_reg(avs_address, sst_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_r <= avs_writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Shift clock edges
    // ------------------------------------------------------------
    sst_sync u_sclk_sync (
        .clock(clock),
        .rst(rst),
        .pin(serial_clock_pin),
        .level(sclk)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= sclk;
        end
    end

    assign slave_mode = ~ctrl_r.master_clock_select & ctrl_r.sync_select;
    assign port_live = slave_mode & rx_status_r[sst_pkg::RXS_PORT_EN] &
                       ctrl_r.transmit_enable_bit;
    assign sclk_rise = sclk & ~sclk_prev_r;
    assign sclk_fall = ~sclk & sclk_prev_r;
    assign load_shift = port_live && hold_full_r &&
                        state_r == sst_pkg::ST_IDLE;
    assign shift_done = (state_r == sst_pkg::ST_LAST) && sclk_rise;

    // ------------------------------------------------------------
    // Holding register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_r <= '0;
            hold_full_r <= 1'b0;
        end else if (wr_take && lane0 &&
                     is_reg(avs_address, sst_pkg::ADDR_TX_HOLD)) begin
            hold_r.data <= avs_writedata[7:0];
            hold_r.ninth <= ctrl_r.ninth_transmit_bit;
            hold_full_r <= 1'b1;
        end else if (load_shift) begin
            hold_full_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transmit flag and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b1;
        end else if (load_shift) begin
            flag_r <= 1'b1;
        end else if (wr_take && lane0 &&
                     is_reg(avs_address, sst_pkg::ADDR_TX_HOLD)) begin
            flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Word-sent event, sticky until a one is written to it
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sent_r <= 1'b0;
        end else if (shift_done) begin
            sent_r <= 1'b1;
        end else if (wr_take && lane0 &&
                     is_reg(avs_address, sst_pkg::ADDR_IRQ_STATUS) &&
                     avs_writedata[sst_pkg::IRQ_SENT]) begin
            sent_r <= 1'b0;
        end
    end

    assign pending = (flag_r & irq_mask_r[sst_pkg::IRQ_TX_FLAG]) |
                     (sent_r & irq_mask_r[sst_pkg::IRQ_SENT]);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= sleep_mode & pending;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= pending & irq_mask_r[sst_pkg::IRQ_GLOBAL_EN] &
                   irq_mask_r[sst_pkg::IRQ_PERIPH_EN];
        end
    end

    // ------------------------------------------------------------
    // Shift register, runs regardless of sleep_mode
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= sst_pkg::ST_IDLE;
            shift_r <= '0;
            bit_cnt_r <= 4'h0;
        end else if (!port_live) begin
            state_r <= sst_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                sst_pkg::ST_IDLE: begin
                    if (load_shift) begin
                        shift_r <= hold_r;
                        bit_cnt_r <= ctrl_r.nine_bit_transmit_enable ?
                                     sst_pkg::SHIFT_CNT_NINE :
                                     sst_pkg::SHIFT_CNT_EIGHT;
                        state_r <= sst_pkg::ST_SHIFT;
                    end
                end
                sst_pkg::ST_SHIFT: begin
                    if (sclk_rise) begin
                        shift_r <= {1'b0, shift_r.ninth, shift_r.data[7:1]};
                        bit_cnt_r <= bit_cnt_r - 4'h1;
                        if (bit_cnt_r == 4'h1) begin
                            state_r <= sst_pkg::ST_LAST;
                        end
                    end
                end
                sst_pkg::ST_LAST: begin
                    if (shift_done) begin
                        state_r <= sst_pkg::ST_IDLE;
                    end
                end
                default: state_r <= sst_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data pin
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_data_out <= 1'b1;
            serial_data_oe_n <= 1'b1;
        end else begin
            serial_data_oe_n <= ~(port_live && state_r != sst_pkg::ST_IDLE);
            if (state_r == sst_pkg::ST_IDLE || sclk_fall ||
                !sclk) begin
                serial_data_out <= (state_r == sst_pkg::ST_IDLE) ?
                                   1'b1 : shift_r.data[0];
            end
        end
    end
endmodule : sst_tx
`default_nettype wire

/* logic/sst_pkg.sv */
// Purpose: Shared constants and types for the synchronous slave transmitter.
// Assumes: Avalon-MM register bus with 32-bit data, one register per word.
// Notes: Byte-wide registers sit in the low bits of each word.
`default_nettype none
package sst_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_TX_STATUS = 5'h00;
    localparam logic [4:0] ADDR_RX_STATUS = 5'h04;
    localparam logic [4:0] ADDR_TX_HOLD = 5'h08;
    localparam logic [4:0] ADDR_BAUD_CTRL = 5'h0c;
    localparam logic [4:0] ADDR_DIV_HIGH = 5'h10;
    localparam logic [4:0] ADDR_DIV_LOW = 5'h14;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h18;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h1c;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TXS_MASTER_CLK = 7;
    localparam int TXS_NINE_BIT = 6;
    localparam int TXS_TX_EN = 5;
    localparam int TXS_SYNC = 4;
    localparam int TXS_SR_EMPTY = 1;
    localparam int TXS_NINTH = 0;
    localparam int RXS_PORT_EN = 7;
    localparam int RXS_SINGLE_RX = 5;
    localparam int RXS_CONT_RX = 4;
    localparam int IRQ_TX_FLAG = 0;
    localparam int IRQ_SENT = 1;
    localparam int IRQ_GLOBAL_EN = 7;
    localparam int IRQ_PERIPH_EN = 6;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TXS_RESET = 8'h02;
    localparam logic [7:0] RXS_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // ------------------------------------------------------------
    // Shift counts before the last bit of a word
    // ------------------------------------------------------------
    localparam logic [3:0] SHIFT_CNT_EIGHT = 4'h7;
    localparam logic [3:0] SHIFT_CNT_NINE = 4'h8;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic master_clock_select;
        logic nine_bit_transmit_enable;
        logic transmit_enable_bit;
        logic sync_select;
        logic ninth_transmit_bit;
    } sst_ctrl_t;
    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } sst_word_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_LAST = 3'b100
    } sst_state_t;
endpackage : sst_pkg
`default_nettype wire

/* logic/sst_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for a pin.
// Assumes: Pin is asynchronous to clock.
// Notes: A change counts once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module sst_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pin and filtered level
    input wire logic pin,
    output logic level
);
    logic [2:0] stage_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage_r <= 3'h0;
        end else begin
            stage_r <= {stage_r[1:0], pin};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
        end else if (stage_r[1] == stage_r[2]) begin
            level <= stage_r[2];
        end
    end
endmodule : sst_sync
`default_nettype wire

/* tb/sst_tx_asserts.sv */
// Purpose: Port checks for the synchronous slave transmitter.
// Assumes: One clock domain with an asynchronous active-high reset.
// Notes: Bound to every instance of sst_tx at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module sst_tx_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    // Serial pins and power
    input wire logic serial_clock_pin,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n,
    input wire logic sleep_mode,
    input wire logic wake_request,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic pin_r;
    logic rise;
    logic fall;
    logic [3:0] since_r;
    logic [4:0] rises_r;
    assign rise = serial_clock_pin && !pin_r;
    assign fall = !serial_clock_pin && pin_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_r <= 1'b0;
            since_r <= 4'hf;
        end else begin
            pin_r <= serial_clock_pin;
            since_r <= fall ? 4'h0 : (since_r == 4'hf ? 4'hf : since_r + 4'h1);
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rises_r <= 5'h00;
        end else if (serial_data_oe_n) begin
            rises_r <= 5'h00;
        end else if (rise) begin
            rises_r <= rises_r + 5'h01;
        end
    end
    chk_wait_pulse: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest stayed low");
    chk_bus_answer: assert property (
        (avs_read || avs_write) && !$past(avs_read || avs_write)
        |=> !avs_waitrequest) else $error("access not answered in time");
    chk_resp_code: assert property (
        !avs_waitrequest && (avs_read || avs_write) |->
        avs_response == {avs_address[1:0] != 2'b00, 1'b0})
        else $error("wrong response code");
    chk_wake_sleep: assert property (
        wake_request |-> $past(sleep_mode)) else $error("wake outside sleep");
    chk_irq_wake: assert property (
        irq && $past(sleep_mode) |-> wake_request)
        else $error("pending interrupt did not wake");
    chk_idle_high: assert property (
        serial_data_oe_n && $past(serial_data_oe_n) |-> serial_data_out)
        else $error("data line not idle high");
    chk_shift_cause: assert property (
        !serial_data_oe_n && $past(!serial_data_oe_n)
        && $changed(serial_data_out) |-> since_r <= 4'h8)
        else $error("data moved without an external clock edge");
    chk_frame_bits: assert property (
        $rose(serial_data_oe_n) |-> rises_r >= 5'h08)
        else $error("word ended before eight clock edges");
    cover property ($rose(wake_request));
    cover property ($rose(irq));
    cover property (!avs_waitrequest && avs_response == 2'b10);
    cover property ($fell(serial_data_oe_n) && sleep_mode);
endmodule : sst_tx_asserts
bind sst_tx sst_tx_asserts u_sst_tx_asserts (
    .clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .serial_clock_pin(serial_clock_pin), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .sleep_mode(sleep_mode),
    .wake_request(wake_request), .irq(irq));
`default_nettype wire

/* tb/sst_master_model.sv */
// Purpose: External synchronous master that clocks words out of the port.
// Assumes: Shift clock idles low; bits are taken on its rising edge.
// Notes: The clock runs only while a word is being taken.
`timescale 1ns/1ns
`default_nettype none
module sst_master_model (
    // Serial pins
    output logic serial_clock_pin,
    input wire logic serial_data_out
);
    initial serial_clock_pin = 1'b0;
    task automatic take_word(input int nbits, output logic [8:0] word);
        word = 9'h000;
        for (int i = 0; i < nbits; i++) begin
            #62 serial_clock_pin = 1'b1;
            word[i] = serial_data_out;
            #63 serial_clock_pin = 1'b0;
        end
    endtask : take_word
endmodule : sst_master_model
`default_nettype wire

/* tb/tb_sst_tx.sv */
// Purpose: Register and serial checks of the slave transmitter.
// Assumes: Avalon-MM master tasks; the model supplies the shift clock.
// Notes: Waits are bounded by a cycle ceiling.
`timescale 1ns/1ns
`default_nettype none
module tb_sst_tx;
    logic clock, rst, avs_read, avs_write, avs_waitrequest, sleep_mode;
    logic serial_clock_pin, serial_data_out, serial_data_oe_n;
    logic wake_request, irq;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [3:0] avs_byteenable;
    logic [1:0] avs_response, resp;
    logic [8:0] word;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    sst_tx u_sst_tx (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .serial_clock_pin(serial_clock_pin),
        .serial_data_out(serial_data_out),
        .serial_data_oe_n(serial_data_oe_n), .sleep_mode(sleep_mode),
        .wake_request(wake_request), .irq(irq));
    sst_master_model u_sst_master_model (
        .serial_clock_pin(serial_clock_pin),
        .serial_data_out(serial_data_out));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic wrap_up();
        $display("samples_checked %0d miscompares %0d", samples_checked,
            miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        resp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h000000, d});
    endtask : wr
    task automatic rd(input string name, input logic [4:0] a,
        input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(name, exp, rdata);
    endtask : rd
    task automatic shift(input int n, input logic [8:0] exp);
        u_sst_master_model.take_word(n, word);
        @(posedge clock);
        check("shifted word", {23'h000000, exp}, {23'h000000, word});
    endtask : shift
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        rst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hf;
        sleep_mode = 1'b0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd("tx status", sst_pkg::ADDR_TX_STATUS, 32'h02);
        rd("flag", sst_pkg::ADDR_IRQ_STATUS, 32'h01);
        rd("unmapped", 5'h02, 32'h00);
        check("response", 32'h2, {30'h0, resp});
        wr(sst_pkg::ADDR_RX_STATUS, 8'h80);
        wr(sst_pkg::ADDR_TX_STATUS, 8'h30);
        wr(sst_pkg::ADDR_IRQ_MASK, 8'hc1);
        repeat (2) @(posedge clock);
        check("irq idle", 32'h1, {31'h0, irq});
        wr(sst_pkg::ADDR_TX_HOLD, 8'ha5);
        wr(sst_pkg::ADDR_TX_HOLD, 8'h3c);
        sleep_mode <= 1'b1;
        rd("flag", sst_pkg::ADDR_IRQ_STATUS, 32'h00);
        rd("tx status", sst_pkg::ADDR_TX_STATUS, 32'h30);
        check("irq busy", 32'h0, {31'h0, irq});
        shift(8, 9'h0a5);
        rd("flag", sst_pkg::ADDR_IRQ_STATUS, 32'h03);
        check("wake", 32'h1, {31'h0, wake_request});
        check("irq set", 32'h1, {31'h0, irq});
        shift(8, 9'h03c);
        rd("tx status", sst_pkg::ADDR_TX_STATUS, 32'h32);
        sleep_mode <= 1'b0;
        wr(sst_pkg::ADDR_TX_STATUS, 8'h71);
        wr(sst_pkg::ADDR_TX_HOLD, 8'h5a);
        shift(9, 9'h15a);
        wr(sst_pkg::ADDR_IRQ_MASK, 8'hc2);
        repeat (2) @(posedge clock);
        check("irq sent", 32'h1, {31'h0, irq});
        wr(sst_pkg::ADDR_IRQ_STATUS, 8'h02);
        rd("sent cleared", sst_pkg::ADDR_IRQ_STATUS, 32'h01);
        check("irq cleared", 32'h0, {31'h0, irq});
        wr(sst_pkg::ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clock);
        check("irq masked", 32'h0, {31'h0, irq});
        check("wake off", 32'h0, {31'h0, wake_request});
        wr(sst_pkg::ADDR_TX_STATUS, 8'hb0);
        wr(sst_pkg::ADDR_TX_HOLD, 8'h11);
        repeat (20) @(posedge clock);
        check("oe_n master", 32'h1, {31'h0, serial_data_oe_n});
        wrap_up();
    end
endmodule : tb_sst_tx
`default_nettype wire
